// ===== logic/opdec_map.svh
// Purpose: Constants for the opcode decoder: lengths, cycle counts, reset values
// Assumes: Eight-bit opcodes, one decode per clock
// Notes: Holds definitions only
`ifndef OPDEC_MAP_SVH
`define OPDEC_MAP_SVH

`define OPC_W 8
`define LEN_W 2
`define CYC_W 3
`define LEN_NONE 2'h0
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
`define CYC_NONE 3'h0
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_FOUR 3'h4
`define OPC_COLLIDE 8'h94
`define OPC_RST 8'h00

`endif

// ===== logic/opdec_pkg.sv
// Purpose: Types shared by the opcode decoder files
// Assumes: opdec_map.svh gives widths
// Notes: Class codes are arbitrary but stable
`include "opdec_map.svh"
package opdec_pkg;
  typedef enum logic [5:0] {
    op_none, op_add, op_add_with_carry, op_subtract_with_borrow, op_increment,
    op_decrement, op_pointer_increment, op_multiply, op_divide, op_decimal_adjust,
    op_logical_and, op_logical_or, op_logical_xor, op_clear_acc, op_complement_acc,
    op_nibble_exchange, op_rotate_left, op_rotate_left_via_carry, op_rotate_right,
    op_rotate_right_via_carry, op_transfer_op, op_pointer_load, op_code_memory_read,
    op_external_data_move, op_stack_push, op_stack_pop, op_operand_swap,
    op_low_nibble_swap, op_bit_clear, op_bit_set, op_complement_op, op_carry_and,
    op_carry_and_inv, op_carry_or, op_carry_or_inv, op_bit_to_carry, op_carry_to_bit
  } op_class_e;

  typedef enum logic [3:0] {
    md_none, md_acc, md_reg, md_direct, md_indirect, md_immediate, md_pointer,
    md_bit, md_carry
  } addr_mode_e;

  typedef struct packed {
    op_class_e cls;
    logic [`LEN_W-1:0] len;
    logic [`CYC_W-1:0] cyc;
  } dec_s;
endpackage

// ===== logic/opdec_mode.sv
// Purpose: Operand addressing mode of an opcode
// Assumes: Combinational, same clock domain as the caller
// Notes: Exact codes are listed before the generic nibble patterns
`timescale 1ns/100ps
`include "opdec_map.svh"
module opdec_mode
  import opdec_pkg::*;
(
  input wire logic [`OPC_W-1:0] i_opcode,
  output addr_mode_e o_mode
);
  always_comb begin
    casez (i_opcode)
      8'hc3, 8'hd3, 8'hb3: begin
        o_mode = md_carry;
      end
      8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92: begin
        o_mode = md_bit;
      end
      8'ha3, 8'h90, 8'h93, 8'he0, 8'hf0: begin
        o_mode = md_pointer;
      end
      8'hc0, 8'hd0, 8'h42, 8'h43, 8'h52, 8'h53, 8'h62, 8'h63: begin
        o_mode = md_direct;
      end
      8'he2, 8'he3, 8'hf2, 8'hf3: begin
        o_mode = md_indirect;
      end
      8'h04, 8'h14, 8'hc4, 8'he4, 8'hf4, 8'h84, 8'ha4, 8'hd4: begin
        o_mode = md_acc;
      end
      8'h03, 8'h13, 8'h23, 8'h33: begin
        o_mode = md_acc;
      end
      8'b????_1???: begin
        o_mode = md_reg;
      end
      8'b????_011?: begin
        o_mode = md_indirect;
      end
      8'b????_0101: begin
        o_mode = md_direct;
      end
      8'b????_0100: begin
        o_mode = md_immediate;
      end
      default: begin
        o_mode = md_none;
      end
    endcase
  end
endmodule

// ===== logic/cpu_opcode_decoder.sv
// Purpose: Decode a first instruction byte into class, operand mode, length, cycles
// Assumes: Opcode and strobe come from fetch logic on the same clock
// Notes: Results appear one clock after the strobe and hold until the next one
`timescale 1ns/100ps
`include "opdec_map.svh"
module cpu_opcode_decoder
  import opdec_pkg::*;
#(
  parameter int OPCODE_W = `OPC_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_opcode_valid,
  input wire logic [`OPC_W-1:0] i_opcode,
  output logic o_dec_valid,
  output op_class_e o_op_class,
  output addr_mode_e o_addr_mode,
  output logic [`LEN_W-1:0] o_length,
  output logic [`CYC_W-1:0] o_cycles,
  output logic o_foreign,
  output logic o_collision
);
  if (OPCODE_W != `OPC_W) begin : g_width_check
    $error("cpu_opcode_decoder serves eight-bit opcodes only");
  end

  dec_s dec_nxt;
  addr_mode_e mode_nxt;
  logic dec_valid_r;
  op_class_e op_class_r;
  addr_mode_e addr_mode_r;
  logic [`LEN_W-1:0] length_r;
  logic [`CYC_W-1:0] cycles_r;
  logic foreign_r;
  logic collision_r;

  opdec_mode u_mode (
    .i_opcode(i_opcode),
    .o_mode(mode_nxt)
  );

  always_comb begin
    casez (i_opcode)
      8'b0010_1???: dec_nxt = {op_add, `LEN_ONE, `CYC_ONE};
      8'h25: dec_nxt = {op_add, `LEN_TWO, `CYC_ONE};
      8'b0010_011?: dec_nxt = {op_add, `LEN_ONE, `CYC_ONE};
      8'h24: dec_nxt = {op_add, `LEN_TWO, `CYC_ONE};
      8'b0011_1???: dec_nxt = {op_add_with_carry, `LEN_ONE, `CYC_ONE};
      8'h35: dec_nxt = {op_add_with_carry, `LEN_TWO, `CYC_ONE};
      8'b0011_011?: dec_nxt = {op_add_with_carry, `LEN_ONE, `CYC_ONE};
      8'h34: dec_nxt = {op_add_with_carry, `LEN_TWO, `CYC_ONE};
      8'b1001_1???: dec_nxt = {op_subtract_with_borrow, `LEN_ONE, `CYC_ONE};
      8'h95: dec_nxt = {op_subtract_with_borrow, `LEN_TWO, `CYC_ONE};
      8'b1001_011?: dec_nxt = {op_subtract_with_borrow, `LEN_ONE, `CYC_ONE};
      // shared code taken as subtract immediate
      `OPC_COLLIDE: dec_nxt = {op_subtract_with_borrow, `LEN_TWO, `CYC_ONE};
      8'h04: dec_nxt = {op_increment, `LEN_ONE, `CYC_ONE};
      8'b0000_1???: dec_nxt = {op_increment, `LEN_ONE, `CYC_ONE};
      8'h05: dec_nxt = {op_increment, `LEN_TWO, `CYC_ONE};
      8'b0000_011?: dec_nxt = {op_increment, `LEN_ONE, `CYC_ONE};
      8'h14: dec_nxt = {op_decrement, `LEN_ONE, `CYC_ONE};
      8'b0001_1???: dec_nxt = {op_decrement, `LEN_ONE, `CYC_ONE};
      8'h15: dec_nxt = {op_decrement, `LEN_TWO, `CYC_ONE};
      8'b0001_011?: dec_nxt = {op_decrement, `LEN_ONE, `CYC_ONE};
      8'ha3: dec_nxt = {op_pointer_increment, `LEN_ONE, `CYC_TWO};
      8'ha4: dec_nxt = {op_multiply, `LEN_ONE, `CYC_FOUR};
      8'h84: dec_nxt = {op_divide, `LEN_ONE, `CYC_FOUR};
      8'hd4: dec_nxt = {op_decimal_adjust, `LEN_ONE, `CYC_ONE};
      8'b0101_1???: dec_nxt = {op_logical_and, `LEN_ONE, `CYC_ONE};
      8'h55: dec_nxt = {op_logical_and, `LEN_TWO, `CYC_ONE};
      8'b0101_011?: dec_nxt = {op_logical_and, `LEN_ONE, `CYC_ONE};
      8'h54: dec_nxt = {op_logical_and, `LEN_TWO, `CYC_ONE};
      8'h52: dec_nxt = {op_logical_and, `LEN_TWO, `CYC_ONE};
      8'h53: dec_nxt = {op_logical_and, `LEN_THREE, `CYC_TWO};
      8'b0100_1???: dec_nxt = {op_logical_or, `LEN_ONE, `CYC_ONE};
      8'h45: dec_nxt = {op_logical_or, `LEN_TWO, `CYC_ONE};
      8'b0100_011?: dec_nxt = {op_logical_or, `LEN_ONE, `CYC_ONE};
      8'h44: dec_nxt = {op_logical_or, `LEN_TWO, `CYC_ONE};
      8'h42: dec_nxt = {op_logical_or, `LEN_TWO, `CYC_ONE};
      8'h43: dec_nxt = {op_logical_or, `LEN_THREE, `CYC_TWO};
      8'b0110_1???: dec_nxt = {op_logical_xor, `LEN_ONE, `CYC_ONE};
      8'h65: dec_nxt = {op_logical_xor, `LEN_TWO, `CYC_ONE};
      8'b0110_011?: dec_nxt = {op_logical_xor, `LEN_ONE, `CYC_ONE};
      8'h64: dec_nxt = {op_logical_xor, `LEN_TWO, `CYC_ONE};
      8'h62: dec_nxt = {op_logical_xor, `LEN_TWO, `CYC_ONE};
      8'h63: dec_nxt = {op_logical_xor, `LEN_THREE, `CYC_TWO};
      8'he4: dec_nxt = {op_clear_acc, `LEN_ONE, `CYC_ONE};
      8'hf4: dec_nxt = {op_complement_acc, `LEN_ONE, `CYC_ONE};
      8'hc4: dec_nxt = {op_nibble_exchange, `LEN_ONE, `CYC_ONE};
      8'h23: dec_nxt = {op_rotate_left, `LEN_ONE, `CYC_ONE};
      8'h33: dec_nxt = {op_rotate_left_via_carry, `LEN_ONE, `CYC_ONE};
      8'h03: dec_nxt = {op_rotate_right, `LEN_ONE, `CYC_ONE};
      8'h13: dec_nxt = {op_rotate_right_via_carry, `LEN_ONE, `CYC_ONE};
      8'b1110_1???: dec_nxt = {op_transfer_op, `LEN_ONE, `CYC_ONE};
      8'he5: dec_nxt = {op_transfer_op, `LEN_TWO, `CYC_ONE};
      8'b1110_011?: dec_nxt = {op_transfer_op, `LEN_ONE, `CYC_ONE};
      8'h74: dec_nxt = {op_transfer_op, `LEN_TWO, `CYC_ONE};
      8'b1111_1???: dec_nxt = {op_transfer_op, `LEN_ONE, `CYC_ONE};
      8'b1010_1???: dec_nxt = {op_transfer_op, `LEN_TWO, `CYC_TWO};
      8'b0111_1???: dec_nxt = {op_transfer_op, `LEN_TWO, `CYC_ONE};
      8'hf5: dec_nxt = {op_transfer_op, `LEN_TWO, `CYC_ONE};
      8'b1000_1???: dec_nxt = {op_transfer_op, `LEN_TWO, `CYC_TWO};
      8'h85: dec_nxt = {op_transfer_op, `LEN_THREE, `CYC_TWO};
      8'b1000_011?: dec_nxt = {op_transfer_op, `LEN_TWO, `CYC_TWO};
      8'h75: dec_nxt = {op_transfer_op, `LEN_THREE, `CYC_TWO};
      8'b1111_011?: dec_nxt = {op_transfer_op, `LEN_ONE, `CYC_ONE};
      8'b1010_011?: dec_nxt = {op_transfer_op, `LEN_TWO, `CYC_TWO};
      8'b0111_011?: dec_nxt = {op_transfer_op, `LEN_TWO, `CYC_ONE};
      8'h90: dec_nxt = {op_pointer_load, `LEN_THREE, `CYC_TWO};
      8'h93: dec_nxt = {op_code_memory_read, `LEN_ONE, `CYC_TWO};
      8'b111?_001?: dec_nxt = {op_external_data_move, `LEN_ONE, `CYC_TWO};
      8'he0, 8'hf0: dec_nxt = {op_external_data_move, `LEN_ONE, `CYC_TWO};
      8'hc0: dec_nxt = {op_stack_push, `LEN_TWO, `CYC_TWO};
      8'hd0: dec_nxt = {op_stack_pop, `LEN_TWO, `CYC_TWO};
      8'b1100_1???: dec_nxt = {op_operand_swap, `LEN_ONE, `CYC_ONE};
      8'hc5: dec_nxt = {op_operand_swap, `LEN_TWO, `CYC_ONE};
      8'b1100_011?: dec_nxt = {op_operand_swap, `LEN_ONE, `CYC_ONE};
      8'b1101_011?: dec_nxt = {op_low_nibble_swap, `LEN_ONE, `CYC_ONE};
      // bit and carry clear, set, complement, then carry logic and bit moves
      8'hc3: dec_nxt = {op_bit_clear, `LEN_ONE, `CYC_ONE};
      8'hc2: dec_nxt = {op_bit_clear, `LEN_TWO, `CYC_ONE};
      8'hd3: dec_nxt = {op_bit_set, `LEN_ONE, `CYC_ONE};
      8'hd2: dec_nxt = {op_bit_set, `LEN_TWO, `CYC_ONE};
      8'hb3: dec_nxt = {op_complement_op, `LEN_ONE, `CYC_ONE};
      8'hb2: dec_nxt = {op_complement_op, `LEN_TWO, `CYC_ONE};
      8'h82: dec_nxt = {op_carry_and, `LEN_TWO, `CYC_TWO};
      8'hb0: dec_nxt = {op_carry_and_inv, `LEN_TWO, `CYC_TWO};
      8'h72: dec_nxt = {op_carry_or, `LEN_TWO, `CYC_TWO};
      8'ha0: dec_nxt = {op_carry_or_inv, `LEN_TWO, `CYC_TWO};
      8'ha2: dec_nxt = {op_bit_to_carry, `LEN_TWO, `CYC_ONE};
      8'h92: dec_nxt = {op_carry_to_bit, `LEN_TWO, `CYC_TWO};
      // everything else belongs to the branch decoder
      default: dec_nxt = {op_none, `LEN_NONE, `CYC_NONE};
    endcase
  end

  // Strobe follows the fetch strobe by one clock
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      dec_valid_r <= 1'b0;
    end else begin
      dec_valid_r <= i_opcode_valid;
    end
  end

  // Decoded fields hold until the next strobe
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      op_class_r <= op_none;
      addr_mode_r <= md_none;
      length_r <= `LEN_NONE;
      cycles_r <= `CYC_NONE;
    end else if (i_opcode_valid) begin
      op_class_r <= dec_nxt.cls;
      addr_mode_r <= mode_nxt;
      length_r <= dec_nxt.len;
      cycles_r <= dec_nxt.cyc;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      foreign_r <= 1'b0;
      collision_r <= 1'b0;
    end else if (i_opcode_valid) begin
      foreign_r <= (dec_nxt.cls == op_none);
      collision_r <= (i_opcode == `OPC_COLLIDE);
    end
  end

  assign o_dec_valid = dec_valid_r;
  assign o_op_class = op_class_r;
  assign o_addr_mode = addr_mode_r;
  assign o_length = length_r;
  assign o_cycles = cycles_r;
  assign o_foreign = foreign_r;
  assign o_collision = collision_r;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  a_add_decode: assert property (
    i_opcode_valid && (i_opcode[7:3] == 5'h05)
    |=> o_op_class == op_add && o_cycles == `CYC_ONE && o_length == `LEN_ONE)
    else $error("add from register misdecoded");
  a_carry_add: assert property (
    i_opcode_valid && i_opcode == 8'h34
    |=> o_op_class == op_add_with_carry && o_length == `LEN_TWO
        && o_addr_mode == md_immediate)
    else $error("add with carry immediate misdecoded");
  a_borrow_sub: assert property (
    i_opcode_valid && (i_opcode[7:1] == 7'h4b)
    |=> o_op_class == op_subtract_with_borrow && o_addr_mode == md_indirect)
    else $error("subtract indirect misdecoded");
  a_incdec_decode: assert property (
    i_opcode_valid && i_opcode == 8'h15
    |=> o_op_class == op_decrement && o_length == `LEN_TWO && o_cycles == `CYC_ONE)
    else $error("decrement direct misdecoded");
  a_ptr_inc: assert property (
    i_opcode_valid && i_opcode == 8'ha3
    |=> o_op_class == op_pointer_increment && o_cycles == `CYC_TWO
        && o_length == `LEN_ONE)
    else $error("pointer increment misdecoded");
  a_and_acc: assert property (
    i_opcode_valid && i_opcode == 8'h55
    |=> o_op_class == op_logical_and && o_addr_mode == md_direct)
    else $error("and direct misdecoded");
  a_and_direct: assert property (
    i_opcode_valid && i_opcode == 8'h53
    |=> o_length == `LEN_THREE && o_cycles == `CYC_TWO)
    else $error("and immediate to direct misdecoded");
  a_or_direct: assert property (
    i_opcode_valid && i_opcode == 8'h43
    |=> o_op_class == op_logical_or && o_length == `LEN_THREE && o_cycles == `CYC_TWO)
    else $error("or immediate to direct misdecoded");
  a_xor_direct: assert property (
    i_opcode_valid && i_opcode == 8'h62
    |=> o_op_class == op_logical_xor && o_cycles == `CYC_ONE)
    else $error("xor to direct misdecoded");
  a_rotate_ops: assert property (
    i_opcode_valid && i_opcode == 8'h33
    |=> o_op_class == op_rotate_left_via_carry && o_addr_mode == md_acc)
    else $error("rotate via carry misdecoded");
  a_acc_load: assert property (
    i_opcode_valid && i_opcode == 8'h74
    |=> o_op_class == op_transfer_op && o_addr_mode == md_immediate)
    else $error("accumulator immediate load misdecoded");
  a_reg_load: assert property (
    i_opcode_valid && (i_opcode[7:3] == 5'h15)
    |=> o_cycles == `CYC_TWO && o_length == `LEN_TWO)
    else $error("register load from direct misdecoded");
  a_direct_load: assert property (
    i_opcode_valid && (i_opcode == 8'h85 || i_opcode == 8'h75)
    |=> o_length == `LEN_THREE && o_cycles == `CYC_TWO)
    else $error("direct load misdecoded");
  a_indir_store: assert property (
    i_opcode_valid && (i_opcode[7:1] == 7'h7b)
    |=> o_op_class == op_transfer_op && o_cycles == `CYC_ONE)
    else $error("indirect store misdecoded");
  a_ptr_load: assert property (
    i_opcode_valid && i_opcode == 8'h90
    |=> o_op_class == op_pointer_load && o_length == `LEN_THREE)
    else $error("pointer load misdecoded");
  a_code_read: assert property (
    i_opcode_valid && i_opcode == 8'h93
    |=> o_op_class == op_code_memory_read && o_cycles == `CYC_TWO)
    else $error("code read misdecoded");
  a_ext_move: assert property (
    i_opcode_valid && (i_opcode[7:5] == 3'h7) && (i_opcode[3:2] == 2'h0)
    && (i_opcode[1:0] != 2'h1)
    |=> o_op_class == op_external_data_move && o_length == `LEN_ONE)
    else $error("external move misdecoded");
  a_stack_ops: assert property (
    i_opcode_valid && (i_opcode == 8'hc0 || i_opcode == 8'hd0)
    |=> (o_cycles == `CYC_TWO && o_length == `LEN_TWO && o_addr_mode == md_direct)
        ##1 ($past(i_opcode_valid) || o_cycles == `CYC_TWO))
    else $error("stack operation misdecoded");
  a_swap_ops: assert property (
    i_opcode_valid && (i_opcode[7:1] == 7'h6b)
    |=> o_op_class == op_low_nibble_swap)
    else $error("nibble swap misdecoded");
  a_bit_ops: assert property (
    i_opcode_valid && i_opcode == 8'hd3
    |=> o_op_class == op_bit_set && o_addr_mode == md_carry)
    else $error("set carry misdecoded");
  a_carry_logic: assert property (
    i_opcode_valid && i_opcode == 8'ha0
    |=> o_op_class == op_carry_or_inv && o_cycles == `CYC_TWO)
    else $error("inverted or to carry misdecoded");
  a_bit_copy: assert property (
    i_opcode_valid && i_opcode == 8'ha2
    |=> o_op_class == op_bit_to_carry && o_cycles == `CYC_ONE)
    else $error("bit to carry misdecoded");
  a_foreign_flag: assert property (
    o_dec_valid |-> o_foreign == (o_op_class == op_none))
    else $error("foreign flag disagrees with class");
  a_collide_flag: assert property (
    i_opcode_valid |=> o_collision == ($past(i_opcode) == `OPC_COLLIDE))
    else $error("collision flag wrong");
  a_strobe_hold: assert property (
    !i_opcode_valid |=> $stable(o_op_class) && $stable(o_cycles) && $stable(o_length)
        && $stable(o_addr_mode) && $stable(o_foreign) && $stable(o_collision))
    else $error("decode changed without strobe");
  a_valid_latency: assert property (
    1'b1 |=> o_dec_valid == $past(i_opcode_valid))
    else $error("decode strobe latency wrong");
  a_inc_reg: assert property (
    i_opcode_valid && (i_opcode[7:3] == 5'h01)
    |=> o_op_class == op_increment && o_addr_mode == md_reg)
    else $error("increment register misdecoded");
  a_and_reg: assert property (
    i_opcode_valid && (i_opcode[7:3] == 5'h0b)
    |=> o_op_class == op_logical_and && o_length == `LEN_ONE)
    else $error("and register misdecoded");
  a_or_imm: assert property (
    i_opcode_valid && i_opcode == 8'h44
    |=> o_op_class == op_logical_or && o_addr_mode == md_immediate && o_length == `LEN_TWO)
    else $error("or immediate misdecoded");
  a_xor_imm: assert property (
    i_opcode_valid && i_opcode == 8'h63
    |=> o_op_class == op_logical_xor && o_length == `LEN_THREE && o_cycles == `CYC_TWO)
    else $error("xor immediate to direct misdecoded");
  a_reg_store: assert property (
    i_opcode_valid && (i_opcode[7:3] == 5'h1f)
    |=> o_op_class == op_transfer_op && o_length == `LEN_ONE && o_cycles == `CYC_ONE)
    else $error("register load from accumulator misdecoded");
  a_indir_direct: assert property (
    i_opcode_valid && (i_opcode[7:1] == 7'h53)
    |=> o_cycles == `CYC_TWO && o_addr_mode == md_indirect)
    else $error("indirect load from direct misdecoded");
  a_ext_pointer: assert property (
    i_opcode_valid && (i_opcode == 8'he0 || i_opcode == 8'hf0)
    |=> o_addr_mode == md_pointer && o_cycles == `CYC_TWO)
    else $error("external move via pointer misdecoded");
  a_bit_clear: assert property (
    i_opcode_valid && i_opcode == 8'hc2
    |=> o_op_class == op_bit_clear && o_addr_mode == md_bit && o_length == `LEN_TWO)
    else $error("clear bit misdecoded");
  a_foreign_zero: assert property (
    o_dec_valid && o_foreign |-> o_length == `LEN_NONE && o_cycles == `CYC_NONE)
    else $error("foreign opcode reports a length");
  a_collide_class: assert property (
    o_dec_valid && o_collision
    |-> o_op_class == op_subtract_with_borrow && o_addr_mode == md_immediate)
    else $error("colliding code resolved wrongly");

  c_two_cycle: cover property (o_dec_valid && o_cycles == `CYC_TWO);
  c_three_byte: cover property (o_dec_valid && o_length == `LEN_THREE);
  c_foreign: cover property (o_dec_valid && o_foreign);
  c_collide: cover property (o_dec_valid && o_collision);
  c_back_to_back: cover property (i_opcode_valid ##1 i_opcode_valid);
endmodule

// ===== verif/fetch_port.sv
// Purpose: Program-memory fetch port that hands opcode bytes to the decoder
// Assumes: The bench raises a fetch request at a rising edge, one byte per request
// Notes: Between fetches the byte lines show the inverse of the last byte, not a held value
`timescale 1ns/100ps
module fetch_port (
  input wire logic i_core_clk,
  input wire logic i_fetch_req,
  input wire logic [7:0] i_fetch_byte,
  output logic o_opcode_valid,
  output logic [7:0] o_opcode
);
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge i_core_clk) begin
    if (i_fetch_req) last_r <= i_fetch_byte;
  end
  assign o_opcode_valid = i_fetch_req;
  assign o_opcode = i_fetch_req ? i_fetch_byte : ~last_r;
endmodule

// ===== verif/cpu_opcode_decoder_bench.sv
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Decode results are checked one clock after each strobe
// Notes: Table rows span opcode ranges; reset, back-to-back and hold cases follow
`timescale 1ns/100ps
module cpu_opcode_decoder_bench
  import opdec_pkg::*;
;
  typedef struct {logic [7:0] lo, hi; op_class_e cls; logic [1:0] len; logic [2:0] cyc;
    addr_mode_e md;} row_s;
  row_s rows[$];
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, opc_valid, dec_valid, foreign, collision;
  logic [7:0] byt = 8'h00, opc;
  op_class_e op_class;
  addr_mode_e addr_mode;
  logic [1:0] length;
  logic [2:0] cycles;
  int err_count = 0, num_checks = 0;
  always #25 clk = ~clk;
  fetch_port i_fetch (.i_core_clk(clk), .i_fetch_req(req), .i_fetch_byte(byt),
    .o_opcode_valid(opc_valid), .o_opcode(opc));
  cpu_opcode_decoder i_dut (.i_core_clk(clk), .i_rst(rst), .i_opcode_valid(opc_valid),
    .i_opcode(opc), .o_dec_valid(dec_valid), .o_op_class(op_class), .o_addr_mode(addr_mode),
    .o_length(length), .o_cycles(cycles), .o_foreign(foreign), .o_collision(collision));
  task automatic r(input logic [7:0] lo, hi, input op_class_e cls, input logic [1:0] len,
    input logic [2:0] cyc, input addr_mode_e md);
    rows.push_back('{lo, hi, cls, len, cyc, md});
  endtask
  // Register, direct, indirect and x4 forms share one layout across the low nibble
  task automatic grp(input logic [3:0] h, input op_class_e cls, input addr_mode_e m4,
    input logic dir);
    r({h, 4'h8}, {h, 4'hf}, cls, 2'h1, 3'h1, md_reg);
    r({h, 4'h5}, {h, 4'h5}, cls, 2'h2, 3'h1, md_direct);
    r({h, 4'h6}, {h, 4'h7}, cls, 2'h1, 3'h1, md_indirect);
    if (m4 != md_none) r({h, 4'h4}, {h, 4'h4}, cls, (m4 == md_acc) ? 2'h1 : 2'h2, 3'h1, m4);
    if (dir) begin
      r({h, 4'h2}, {h, 4'h2}, cls, 2'h2, 3'h1, md_direct);
      r({h, 4'h3}, {h, 4'h3}, cls, 2'h3, 3'h2, md_direct);
    end
  endtask
  // Mode is compared only where a row names one, or in reset
  task automatic chk(input logic rs, dv, input logic [7:0] op, input op_class_e cls,
    input logic [1:0] len, input logic [2:0] cyc, input addr_mode_e md);
    num_checks++;
    if (dec_valid !== dv || op_class !== cls || length !== len || cycles !== cyc
        || foreign !== (!rs && cls == op_none) || collision !== (!rs && op == 8'h94)
        || ((rs || md != md_none) && addr_mode !== md)) begin
      err_count++;
      $display("MISMATCH %0t opcode %h class %0d len %h cyc %h", $time, op, op_class,
        length, cycles);
    end
  endtask
  task automatic put(input logic v, input logic [7:0] op);
    @(posedge clk);
    req <= v;
    byt <= op;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    grp(4'h2, op_add, md_immediate, 1'b0);
    grp(4'h3, op_add_with_carry, md_immediate, 1'b0);
    grp(4'h9, op_subtract_with_borrow, md_immediate, 1'b0);
    grp(4'h0, op_increment, md_acc, 1'b0);
    grp(4'h1, op_decrement, md_acc, 1'b0);
    grp(4'h5, op_logical_and, md_immediate, 1'b1);
    grp(4'h4, op_logical_or, md_immediate, 1'b1);
    grp(4'h6, op_logical_xor, md_immediate, 1'b1);
    grp(4'he, op_transfer_op, md_none, 1'b0);
    grp(4'hc, op_operand_swap, md_none, 1'b0);
    r(8'h74,8'h74,op_transfer_op,2'h2,3'h1,md_immediate);
    r(8'h23,8'h23,op_rotate_left,2'h1,3'h1,md_acc);
    r(8'h33,8'h33,op_rotate_left_via_carry,2'h1,3'h1,md_acc);
    r(8'h03,8'h03,op_rotate_right,2'h1,3'h1,md_acc);
    r(8'h13,8'h13,op_rotate_right_via_carry,2'h1,3'h1,md_acc);
    r(8'hf8,8'hff,op_transfer_op,2'h1,3'h1,md_reg);
    r(8'ha8,8'haf,op_transfer_op,2'h2,3'h2,md_reg);
    r(8'h78,8'h7f,op_transfer_op,2'h2,3'h1,md_reg);
    r(8'hf5,8'hf5,op_transfer_op,2'h2,3'h1,md_direct);
    r(8'h88,8'h8f,op_transfer_op,2'h2,3'h2,md_reg);
    r(8'h85,8'h85,op_transfer_op,2'h3,3'h2,md_direct);
    r(8'h86,8'h87,op_transfer_op,2'h2,3'h2,md_indirect);
    r(8'h75,8'h75,op_transfer_op,2'h3,3'h2,md_direct);
    r(8'hf6,8'hf7,op_transfer_op,2'h1,3'h1,md_indirect);
    r(8'ha6,8'ha7,op_transfer_op,2'h2,3'h2,md_indirect);
    r(8'h76,8'h77,op_transfer_op,2'h2,3'h1,md_indirect);
    r(8'h90,8'h90,op_pointer_load,2'h3,3'h2,md_pointer);
    r(8'h93,8'h93,op_code_memory_read,2'h1,3'h2,md_pointer);
    r(8'he2,8'he3,op_external_data_move,2'h1,3'h2,md_indirect);
    r(8'hf2,8'hf3,op_external_data_move,2'h1,3'h2,md_indirect);
    r(8'he0,8'he0,op_external_data_move,2'h1,3'h2,md_pointer);
    r(8'hf0,8'hf0,op_external_data_move,2'h1,3'h2,md_pointer);
    r(8'hc0,8'hc0,op_stack_push,2'h2,3'h2,md_direct);
    r(8'hd0,8'hd0,op_stack_pop,2'h2,3'h2,md_direct);
    r(8'hd6,8'hd7,op_low_nibble_swap,2'h1,3'h1,md_indirect);
    r(8'hc2,8'hc2,op_bit_clear,2'h2,3'h1,md_bit);
    r(8'hd2,8'hd2,op_bit_set,2'h2,3'h1,md_bit);
    r(8'hb2,8'hb2,op_complement_op,2'h2,3'h1,md_bit);
    r(8'hc3,8'hc3,op_bit_clear,2'h1,3'h1,md_carry);
    r(8'hd3,8'hd3,op_bit_set,2'h1,3'h1,md_carry);
    r(8'hb3,8'hb3,op_complement_op,2'h1,3'h1,md_carry);
    r(8'h82,8'h82,op_carry_and,2'h2,3'h2,md_bit);
    r(8'hb0,8'hb0,op_carry_and_inv,2'h2,3'h2,md_bit);
    r(8'h72,8'h72,op_carry_or,2'h2,3'h2,md_bit);
    r(8'ha0,8'ha0,op_carry_or_inv,2'h2,3'h2,md_bit);
    r(8'ha2,8'ha2,op_bit_to_carry,2'h2,3'h1,md_bit);
    r(8'h92,8'h92,op_carry_to_bit,2'h2,3'h2,md_bit);
    r(8'ha4,8'ha4,op_multiply,2'h1,3'h4,md_acc);
    r(8'h84,8'h84,op_divide,2'h1,3'h4,md_acc);
    r(8'hd4,8'hd4,op_decimal_adjust,2'h1,3'h1,md_acc);
    r(8'he4,8'he4,op_clear_acc,2'h1,3'h1,md_acc);
    r(8'hf4,8'hf4,op_complement_acc,2'h1,3'h1,md_acc);
    r(8'hc4,8'hc4,op_nibble_exchange,2'h1,3'h1,md_acc);
    r(8'h00,8'h02,op_none,2'h0,3'h0,md_none);
    r(8'hb4,8'hbf,op_none,2'h0,3'h0,md_none);
    r(8'hd8,8'hdf,op_none,2'h0,3'h0,md_none);
    r(8'hd5,8'hd5,op_none,2'h0,3'h0,md_none);
    r(8'ha5,8'ha5,op_none,2'h0,3'h0,md_none);
    r(8'h73,8'h73,op_none,2'h0,3'h0,md_none);
    r(8'h80,8'h80,op_none,2'h0,3'h0,md_none);
    // Every code of the x1 column is a branch
    for (int h = 0; h < 16; h++) begin
      r({h[3:0], 4'h1}, {h[3:0], 4'h1}, op_none, 2'h0, 3'h0, md_none);
    end
    repeat (10) @(posedge clk);
    chk(1'b1, 1'b0, 8'h00, op_none, 2'h0, 3'h0, md_none);
    rst <= 1'b0;
    put(1'b0, 8'h00);
    #1 chk(1'b1, 1'b0, 8'h00, op_none, 2'h0, 3'h0, md_none);
    foreach (rows[i]) begin
      for (int v = int'(rows[i].lo); v <= int'(rows[i].hi); v++) begin
        put(1'b1, v[7:0]);
        put(1'b0, 8'h00);
        #1 chk(1'b0, 1'b1, v[7:0], rows[i].cls, rows[i].len, rows[i].cyc, rows[i].md);
      end
    end
    // Back-to-back strobes, then a hold with the strobe low
    put(1'b1, 8'h53);
    put(1'b1, 8'h94);
    #1 chk(1'b0, 1'b1, 8'h53, op_logical_and, 2'h3, 3'h2, md_direct);
    put(1'b1, 8'ha3);
    #1 chk(1'b0, 1'b1, 8'h94, op_subtract_with_borrow, 2'h2, 3'h1, md_immediate);
    put(1'b0, 8'h00);
    #1 chk(1'b0, 1'b1, 8'ha3, op_pointer_increment, 2'h1, 3'h2, md_pointer);
    @(posedge clk);
    #1 chk(1'b0, 1'b0, 8'ha3, op_pointer_increment, 2'h1, 3'h2, md_pointer);
    // Reset in mid-run, then a strobe at the first edge after release
    @(posedge clk);
    rst <= 1'b1;
    #1 chk(1'b1, 1'b0, 8'h00, op_none, 2'h0, 3'h0, md_none);
    @(posedge clk);
    rst <= 1'b0;
    put(1'b1, 8'h84);
    #1 chk(1'b1, 1'b0, 8'h00, op_none, 2'h0, 3'h0, md_none);
    put(1'b0, 8'h00);
    #1 chk(1'b0, 1'b1, 8'h84, op_divide, 2'h1, 3'h4, md_acc);
    end_sim();
  end
endmodule
